//--- rtl/pic_consts.vh
// constants and register map of the prioritized interrupt controller
// Functional notes
// RULE_01: each of the ten sources has its own enable bit that software sets or clears.
// RULE_02: one global enable bit, when zero, blocks every source regardless of the per-source enables.
// RULE_03: each source has a two-bit level from a high bit and a low bit, 0 lowest and 3 highest; the code gives bus, converter and bus overflow no low bit.
// RULE_04: a routine in service is preempted only by a request of strictly higher level.
// RULE_05: a routine running at level 3 is never preempted.
// RULE_06: among requests seen together, the one with the higher level is vectored.
// RULE_07: equal-level ties are broken by the fixed polling order ext0, t0, ext1, t1, counter array, serial, t2, bus, converter, bus timer overflow.
// RULE_08: the bus controller source is raised by transmit-ok, receive-ok, error or overrun, vector 003bh, rank 8.
// RULE_09: the bus timer overflow is its own request with vector 004bh and the lowest rank 10.
// RULE_10: vectors are ext0 0003h, t0 000bh, ext1 0013h, t1 001bh, serial 0023h, t2 002bh, counter array 0033h, converter 0043h.
// RULE_11: the low-priority register holds ext0 to counter array in bits 0 to 6.
// RULE_12: bit 7 of the low-priority register is reserved, reads are undefined and software never writes one.
// RULE_13: the low-priority register resets to zero in bits 6 to 0 and each bit can be written on its own.
// RULE_14: a source's low bit combines with its high bit to give its level.
// RULE_15: during a precision conversion in pseudo-idle other requests are held until it ends.
// RULE_16: only the conversion-done interrupt wakes the core from pseudo-idle, so software must enable it first.
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH
`define PIC_NSRC        10
// register word byte addresses
`define PIC_REG_ENABLE  8'h00
`define PIC_REG_PLOW    8'hb8
`define PIC_REG_PHIGH   8'h04
`define PIC_REG_STATUS  8'h08
`define PIC_REG_MASK    8'h0c
`define PIC_REG_SERVICE 8'h10
`define PIC_REG_BITSET  8'h14
`define PIC_REG_BITCLR  8'h18
`define PIC_GLOBAL_BIT  15
`define PIC_RST_ENABLE  16'h0000
`define PIC_RST_PLOW    7'h00
`define PIC_RST_PHIGH   10'h000
`define PIC_RST_MASK    3'h0
// status bits
`define PIC_ST_TAKEN    0
`define PIC_ST_RETURN   1
`define PIC_ST_WAKE     2
// source indices in polling order
`define PIC_SRC_EXT0    0
`define PIC_SRC_T0      1
`define PIC_SRC_EXT1    2
`define PIC_SRC_T1      3
`define PIC_SRC_CA      4
`define PIC_SRC_SER     5
`define PIC_SRC_T2      6
`define PIC_SRC_BUS     7
`define PIC_SRC_CONV    8
`define PIC_SRC_BOVF    9
`define PIC_VEC_EXT0    16'h0003
`define PIC_VEC_T0      16'h000b
`define PIC_VEC_EXT1    16'h0013
`define PIC_VEC_T1      16'h001b
`define PIC_VEC_SER     16'h0023
`define PIC_VEC_T2      16'h002b
`define PIC_VEC_CA      16'h0033
`define PIC_VEC_BUS     16'h003b
`define PIC_VEC_CONV    16'h0043
`define PIC_VEC_BOVF    16'h004b
`endif

//--- rtl/pic_core.v
// prioritized interrupt controller with avalon-mm register slave
//
// The Avalon-MM register port was left to the implementer.
`include "pic_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module pic_core #(
  parameter NSRC = `PIC_NSRC
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire        external_irq_zero,
  input  wire        external_irq_one,
  input  wire        timer0_overflow_flag,
  input  wire        timer1_overflow_flag,
  input  wire        timer2_overflow_flag,
  input  wire        counter_array_overflow_flag,
  input  wire        module_match_flag,
  input  wire        serial_receive_flag,
  input  wire        serial_transmit_flag,
  input  wire        bus_transmit_ok_flag,
  input  wire        bus_receive_ok_flag,
  input  wire        bus_error_flag,
  input  wire        bus_buffer_overrun_flag,
  input  wire        bus_timer_overflow_flag,
  input  wire        conversion_done_flag,
  input  wire        pseudo_idle_select,
  output reg         core_irq,
  output reg  [15:0] core_vector,
  output reg  [3:0]  core_source,
  input  wire        core_ack,
  input  wire        core_reti,
  output reg         core_wake,
  output wire        irq
);

  // bus handshake states
  localparam [1:0] st_idle = 2'b01;
  localparam [1:0] st_resp = 2'b10;

  reg  [1:0]      bus_state;
  reg  [NSRC-1:0] src_meta;
  reg  [NSRC-1:0] src_sync;
  reg             pidle_meta;
  reg             pidle_sync;
  reg  [15:0]     enable;
  reg  [6:0]      priority_low_reg;
  reg  [9:0]      level_high_bit;
  reg  [2:0]      status;
  reg  [2:0]      mask;
  reg  [3:0]      in_service;
  reg  [1:0]      cur_level;
  reg  [3:0]      stack_depth;
  reg  [7:0]      level_stack;
  wire [NSRC-1:0] raw_req;
  wire [NSRC-1:0] level_low_bit;
  wire [NSRC-1:0] gated;
  reg  [3:0]      win_src;
  reg  [1:0]      win_level;
  reg             win_valid;
  reg  [15:0]     win_vector;
  reg  [2:0]      st_event;
  integer         i;

  // raw requests in polling order
  assign raw_req[`PIC_SRC_EXT0] = external_irq_zero;
  assign raw_req[`PIC_SRC_T0]   = timer0_overflow_flag;
  assign raw_req[`PIC_SRC_EXT1] = external_irq_one;
  assign raw_req[`PIC_SRC_T1]   = timer1_overflow_flag;
  assign raw_req[`PIC_SRC_CA]   = counter_array_overflow_flag |
                                  module_match_flag;
  assign raw_req[`PIC_SRC_SER]  = serial_receive_flag | serial_transmit_flag;
  assign raw_req[`PIC_SRC_T2]   = timer2_overflow_flag;
  assign raw_req[`PIC_SRC_BUS]  = bus_transmit_ok_flag | bus_receive_ok_flag |
                                  bus_error_flag | bus_buffer_overrun_flag;   // RULE_08
  assign raw_req[`PIC_SRC_BOVF] = bus_timer_overflow_flag;                    // RULE_09
  assign raw_req[`PIC_SRC_CONV] = conversion_done_flag;

  // low level bits mapped to polling index
  assign level_low_bit = {3'b000, priority_low_reg};
  wire [NSRC-1:0] low_by_poll;
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_low
      if (g == `PIC_SRC_CA) begin : g_ca
        assign low_by_poll[g] = level_low_bit[6];          // RULE_11
      end else if (g == `PIC_SRC_SER) begin : g_ser
        assign low_by_poll[g] = level_low_bit[4];          // RULE_11
      end else if (g == `PIC_SRC_T2) begin : g_t2
        assign low_by_poll[g] = level_low_bit[5];          // RULE_11
      end else if (g < 7) begin : g_same
        assign low_by_poll[g] = level_low_bit[g];          // RULE_11
      end else begin : g_none
        // bus, converter and bus overflow have no low bit
        assign low_by_poll[g] = 1'b0;
      end
    end
  endgenerate

  // enable gating, global bit overrides all
  assign gated = src_sync & enable[NSRC-1:0] &
                 {NSRC{enable[`PIC_GLOBAL_BIT]}};            // RULE_01 RULE_02

  // pseudo idle leaves only the converter eligible, the rest wait
  wire [NSRC-1:0] conv_only;
  assign conv_only = {{(NSRC-1){1'b0}}, 1'b1} << `PIC_SRC_CONV;
  wire [NSRC-1:0] eligible;
  assign eligible = pidle_sync ? (gated & conv_only) : gated;  // RULE_15

  function [15:0] vec_of;
    input [3:0] s;
    begin
      case (s)
        `PIC_SRC_EXT0: vec_of = `PIC_VEC_EXT0;
        `PIC_SRC_T0:   vec_of = `PIC_VEC_T0;
        `PIC_SRC_EXT1: vec_of = `PIC_VEC_EXT1;
        `PIC_SRC_T1:   vec_of = `PIC_VEC_T1;
        `PIC_SRC_CA:   vec_of = `PIC_VEC_CA;
        `PIC_SRC_SER:  vec_of = `PIC_VEC_SER;
        `PIC_SRC_T2:   vec_of = `PIC_VEC_T2;
        `PIC_SRC_BUS:  vec_of = `PIC_VEC_BUS;                // RULE_08
        `PIC_SRC_CONV: vec_of = `PIC_VEC_CONV;
        `PIC_SRC_BOVF: vec_of = `PIC_VEC_BOVF;               // RULE_09
        default:       vec_of = 16'h0000;
      endcase                                                // RULE_10
    end
  endfunction

  // two-bit level of a source in polling order
  function [1:0] level_of;
    input [NSRC-1:0] hi;
    input [NSRC-1:0] lo;
    input [3:0]      s;
    begin
      level_of = {hi[s], lo[s]};                             // RULE_14
    end
  endfunction

  // arbitration: highest level first, lowest index wins ties
  always @* begin
    win_src   = 4'h0;
    win_level = 2'b00;
    win_valid = 1'b0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (eligible[i] && (!win_valid ||
          level_of(level_high_bit, low_by_poll, i[3:0]) >= win_level)) begin
        win_src   = i[3:0];                                  // RULE_06 RULE_07
        win_level = level_of(level_high_bit, low_by_poll, i[3:0]);  // RULE_03
        win_valid = 1'b1;
      end
    end
    win_vector = vec_of(win_src);
  end

  // preemption test
  wire preempt_ok;
  assign preempt_ok = (stack_depth == 4'h0) ||
                      ((cur_level != 2'b11) && (win_level > cur_level));  // RULE_04 RULE_05
  wire take;
  assign take = win_valid && preempt_ok && !core_irq;

  // synchronise asynchronous event inputs
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      src_meta   <= {NSRC{1'b0}};
      src_sync   <= {NSRC{1'b0}};
      pidle_meta <= 1'b0;
      pidle_sync <= 1'b0;
    end else begin
      src_meta   <= raw_req;
      src_sync   <= src_meta;
      pidle_meta <= pseudo_idle_select;
      pidle_sync <= pidle_meta;
    end
  end

  // vector request, nesting stack
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_irq    <= 1'b0;
      core_vector <= 16'h0000;
      core_source <= 4'h0;
      core_wake   <= 1'b0;
      cur_level   <= 2'b00;
      stack_depth <= 4'h0;
      level_stack <= 8'h00;
      in_service  <= 4'h0;
    end else begin
      core_wake <= 1'b0;
      if (take) begin
        core_irq    <= 1'b1;
        core_vector <= win_vector;
        core_source <= win_src;
        core_wake   <= pidle_sync;                            // RULE_16
      end else if (core_ack) begin
        core_irq    <= 1'b0;
      end
      // nesting runs apart from the request; a return in the same cycle as an acknowledge is dropped
      if (core_ack && core_irq) begin
        level_stack <= {level_stack[5:0], cur_level};
        cur_level   <= level_of(level_high_bit, low_by_poll, core_source);
        stack_depth <= stack_depth + 4'h1;
        in_service  <= core_source;
      end else if (core_reti && stack_depth != 4'h0) begin
        cur_level   <= level_stack[1:0];
        level_stack <= {2'b00, level_stack[7:2]};
        stack_depth <= stack_depth - 4'h1;
      end
    end
  end

  // sticky status events
  always @* begin
    st_event = 3'b000;
    st_event[`PIC_ST_TAKEN]  = take;
    st_event[`PIC_ST_RETURN] = core_reti && !(core_ack && core_irq) &&
                               stack_depth != 4'h0;
    st_event[`PIC_ST_WAKE]   = take && pidle_sync;
  end

  wire wr_hit;
  // a write lands at the edge that ends the response cycle, one edge after the wait state ends
  assign wr_hit = (bus_state == st_resp) && avs_write;
  wire [31:0] wmask;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wdat;
  assign wdat = avs_writedata & wmask;

  // register writes
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable           <= `PIC_RST_ENABLE;
      priority_low_reg <= `PIC_RST_PLOW;                      // RULE_13
      level_high_bit   <= `PIC_RST_PHIGH;
      mask             <= `PIC_RST_MASK;
      status           <= 3'b000;
    end else begin
      // set wins over write-one clear
      status <= (status & ~((wr_hit && avs_address == `PIC_REG_STATUS) ?
                            wdat[2:0] : 3'b000)) | st_event;
      if (wr_hit) begin
        case (avs_address)
          `PIC_REG_ENABLE:
            enable <= (enable & ~wmask[15:0]) | wdat[15:0];
          `PIC_REG_PLOW:
            priority_low_reg <= (priority_low_reg & ~wmask[6:0]) |
                                wdat[6:0];                   // RULE_12
          `PIC_REG_PHIGH:
            level_high_bit <= (level_high_bit & ~wmask[9:0]) | wdat[9:0];
          `PIC_REG_MASK:
            mask <= (mask & ~wmask[2:0]) | wdat[2:0];
          `PIC_REG_BITSET:
            if (avs_byteenable[0] && wdat[2:0] != 3'h7)
              priority_low_reg[wdat[2:0]] <= 1'b1;           // RULE_13
          `PIC_REG_BITCLR:
            if (avs_byteenable[0] && wdat[2:0] != 3'h7)
              priority_low_reg[wdat[2:0]] <= 1'b0;           // RULE_13
          default: ;
        endcase
      end
    end
  end

  // bus handshake and read data
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_state    <= st_idle;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'b00;
    end else begin
      case (bus_state)
        st_idle:
          if (avs_read || avs_write) begin
            bus_state    <= st_resp;
            avs_response <= 2'b00;
            avs_readdata <= 32'h00000000;
            case (avs_address)
              `PIC_REG_ENABLE:  avs_readdata <= {16'h0000, enable};
              `PIC_REG_PLOW:    avs_readdata <= {25'h0, priority_low_reg};  // RULE_12
              `PIC_REG_PHIGH:   avs_readdata <= {22'h0, level_high_bit};
              `PIC_REG_STATUS:  avs_readdata <= {29'h0, status};
              `PIC_REG_MASK:    avs_readdata <= {29'h0, mask};
              `PIC_REG_SERVICE: avs_readdata <= {24'h0, cur_level,
                                                 stack_depth[1:0], in_service};
              `PIC_REG_BITSET, `PIC_REG_BITCLR: ;
              default:          avs_response <= 2'b10;
            endcase
          end
        st_resp:
          bus_state <= st_idle;
        default:
          bus_state <= st_idle;
      endcase
    end
  end

  // request held until the response cycle
  assign avs_waitrequest = (avs_read || avs_write) && (bus_state != st_resp);
  assign irq = |(status & mask);

endmodule // pic_core
`default_nettype wire

//--- sim/pic_props.sv
// port assertions for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module pic_props (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        pseudo_idle_select,
  input wire logic        core_irq,
  input wire logic [15:0] core_vector,
  input wire logic [3:0]  core_source,
  input wire logic        core_ack,
  input wire logic        core_wake
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [15:0] vt [10] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033,
                           16'h0023, 16'h002b, 16'h003b, 16'h0043, 16'h004b};
  wire req = avs_read || avs_write;
  wire acc = req && !avs_waitrequest;
  wire hit = avs_address inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                                 8'h18, 8'hb8};
  a_wait_one:
    assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_resp_code:
    assert property (acc |-> avs_response == (hit ? 2'b00 : 2'b10))
    else $error("bus response wrong");
  a_plow_reserved:
    assert property (acc && avs_read && avs_address == 8'hb8
                     |-> avs_readdata[31:7] == 25'h0)
    else $error("priority low upper bits set");
  a_irq_hold:
    assert property (core_irq && !core_ack |=> core_irq
                     && $stable(core_vector) && $stable(core_source))
    else $error("vector request not held");
  a_irq_drop:
    assert property (core_irq && core_ack |=> !core_irq)
    else $error("vector request not dropped");
  a_vec_map:
    assert property (core_irq |-> core_vector == vt[core_source])
    else $error("vector address wrong");
  a_pidle_hold:
    assert property ($rose(core_irq) && $past(pseudo_idle_select, 1)
      && $past(pseudo_idle_select, 2) && $past(pseudo_idle_select, 3)
      && $past(pseudo_idle_select, 4) |-> core_source == 4'h8)
    else $error("request served in pseudo idle");
  a_wake_pulse:
    assert property (core_wake |=> !core_wake)
    else $error("wake longer than one cycle");
endmodule // pic_props
bind pic_core pic_props u_props (.mclk, .resetn, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .avs_response,
  .pseudo_idle_select, .core_irq, .core_vector, .core_source, .core_ack,
  .core_wake);
`default_nettype wire

//--- sim/pic_cpu_model.sv
// processor core model that accepts vectors and ends service
`timescale 1ns/1ns
`default_nettype none
module pic_cpu_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        core_irq,
  input  wire logic [15:0] core_vector,
  input  wire logic [3:0]  core_source,
  input  wire logic [3:0]  ack_wait,
  input  wire logic        reti_req,
  output var  logic        core_ack,
  output var  logic        core_reti,
  output var  logic        taken,
  output var  logic [3:0]  taken_src,
  output var  logic [15:0] taken_vec
);
  int cnt;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_ack <= 0;
      core_reti <= 0;
      taken <= 0;
      taken_src <= 0;
      taken_vec <= 0;
      cnt <= 0;
    end else begin
      core_ack <= 0;
      taken <= 0;
      core_reti <= reti_req;
      // ack only while a request stands, after a chosen delay
      if (core_irq === 1'b1 && !core_ack) begin
        cnt <= cnt + 1;
        if (cnt >= ack_wait) begin
          core_ack <= 1;
          taken <= 1;
          taken_src <= core_source;
          taken_vec <= core_vector;
          cnt <= 0;
        end
      end
    end
  end
endmodule // pic_cpu_model
`default_nettype wire

//--- sim/prioritized_interrupt_controller_bench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module prioritized_interrupt_controller_bench;
  logic        mclk = 0, resetn = 0, avs_read = 0, avs_write = 0, pid = 0;
  logic        rt = 0, tk, irq_o, cirq, cack, creti, cwake, wk = 0, g;
  logic [7:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, rdata, q;
  logic [1:0]  resp, r;
  logic [14:0] fl = 0;
  logic [3:0]  aw = 0, tsrc, csrc, a;
  logic [15:0] tvec, cvec;
  logic [9:0]  s, en, ph;
  logic [6:0]  pl;
  logic [4:0]  got;
  logic [1:0]  la [4] = '{1, 2, 3, 0};
  logic [1:0]  lb [4] = '{2, 2, 3, 1};
  logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'hb8, 8'h0c, 8'h40};
  logic [15:0] vt [10] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033,
                           16'h0023, 16'h002b, 16'h003b, 16'h0043, 16'h004b};
  wire         wt;
  int          bad_count = 0, n_compared = 0, e;
  pic_core uut (.mclk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wt), .avs_response(resp),
    .external_irq_zero(fl[0]), .timer0_overflow_flag(fl[1]),
    .external_irq_one(fl[2]), .timer1_overflow_flag(fl[3]),
    .counter_array_overflow_flag(fl[4]), .module_match_flag(fl[5]),
    .serial_receive_flag(fl[6]), .serial_transmit_flag(fl[7]),
    .timer2_overflow_flag(fl[8]), .bus_transmit_ok_flag(fl[9]),
    .bus_receive_ok_flag(fl[10]), .bus_error_flag(fl[11]),
    .bus_buffer_overrun_flag(fl[12]), .bus_timer_overflow_flag(fl[13]),
    .conversion_done_flag(fl[14]), .pseudo_idle_select(pid),
    .core_irq(cirq), .core_vector(cvec), .core_source(csrc),
    .core_ack(cack), .core_reti(creti), .core_wake(cwake), .irq(irq_o));
  pic_cpu_model cpu (.mclk, .resetn, .core_irq(cirq), .core_vector(cvec),
    .core_source(csrc), .ack_wait(aw), .reti_req(rt), .core_ack(cack),
    .core_reti(creti), .taken(tk), .taken_src(tsrc), .taken_vec(tvec));
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) if (cwake === 1'b1) wk <= 1;
  task automatic print_verdict;
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] sn, ex);
    n_compared++;
    if (sn !== ex) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = rdata;
    r = resp;
    avs_read <= 0;
    avs_write <= 0;
    if (wt !== 1'b0) begin
      bad_count++;
      print_verdict;
    end
  endtask
  task automatic cfg(input logic [15:0] ev, input logic [6:0] lo,
                     input logic [9:0] hi);
    bus(1, 8'h00, {16'h0, ev});
    bus(1, 8'hb8, {25'h0, lo});
    bus(1, 8'h04, {22'h0, hi});
  endtask
  task automatic take(input int lim);
    got = 5'h1f;
    repeat (lim) begin
      @(posedge mclk);
      if (tk === 1'b1) begin
        got = {1'b0, tsrc};
        break;
      end
    end
  endtask
  task automatic ret;
    @(posedge mclk);
    rt <= 1;
    @(posedge mclk);
    rt <= 0;
  endtask
  function automatic logic [14:0] fl_of(logic [9:0] sv, logic [3:0] av);
    return {sv[8], sv[9], ({3'h0, sv[7]} << av[3:2]), sv[6], sv[5] & av[1],
            sv[5] & !av[1], sv[4] & av[0], sv[4] & !av[0], sv[3:0]};
  endfunction
  function automatic int win(logic [9:0] sv, ev, logic [6:0] lo,
                             logic [9:0] hi);
    int lm [7] = '{0, 1, 2, 3, 6, 4, 5};
    int b = 31, bl = -1, lv;
    for (int i = 0; i < 10; i++) begin
      lv = 2 * hi[i] + (i < 7 ? lo[lm[i]] : 0);
      if (sv[i] && ev[i] && lv > bl) begin
        b = i;
        bl = lv;
      end
    end
    return b;
  endfunction
  initial begin
    void'($urandom(45));
    repeat (12) @(posedge mclk);
    resetn <= 1;
    foreach (ra[i]) begin
      bus(0, ra[i], 0);
      chk("resp", r, ra[i] == 8'h40 ? 2 : 0);
      chk("reset", q, 0);
    end
    bus(1, 8'h14, 6);
    bus(0, 8'hb8, 0);
    chk("bitset", q, 32'h40);
    bus(1, 8'h18, 6);
    bus(0, 8'hb8, 0);
    chk("bitclr", q, 0);
    repeat (24) begin
      s = $urandom;
      en = $urandom;
      pl = $urandom;
      ph = $urandom;
      a = $urandom;
      aw <= $urandom % 4;
      g = $urandom % 4 != 0;
      cfg({g, 5'h0, en}, pl, ph);
      bus(0, 8'hb8, 0);
      chk("plow", q, pl);
      fl <= fl_of(s, a);
      e = g ? win(s, en, pl, ph) : 31;
      take(12);
      chk("winner", got, e);
      if (got != 31) chk("vector", tvec, vt[got]);
      fl <= 0;
      repeat (4) @(posedge mclk);
      if (got != 31) ret;
      repeat (4) @(posedge mclk);
    end
    foreach (la[i]) begin
      cfg(16'h800a, {3'h0, lb[i][0], 1'b0, la[i][0], 1'b0},
          {6'h0, lb[i][1], 1'b0, la[i][1], 1'b0});
      fl <= 15'h2;
      take(12);
      chk("first", got, 1);
      fl <= 15'ha;
      take(12);
      chk("nest", got, lb[i] > la[i] && la[i] != 3 ? 3 : 31);
      fl <= 0;
      repeat (4) @(posedge mclk);
      if (got != 31) ret;
      ret;
      repeat (4) @(posedge mclk);
    end
    pid <= 1;
    cfg(16'h83ff, 7'h02, 10'h002);
    fl <= 15'h4002;
    take(12);
    chk("pidle", got, 8);
    fl <= 15'h2;
    pid <= 0;
    take(12);
    chk("after", got, 1);
    chk("wake", wk, 1);
    fl <= 0;
    repeat (4) @(posedge mclk);
    ret;
    ret;
    chk("irqmask", irq_o, 0);
    bus(1, 8'h0c, 1);
    @(posedge mclk);
    chk("irqset", irq_o, 1);
    bus(1, 8'h08, 1);
    @(posedge mclk);
    chk("irqclr", irq_o, 0);
    print_verdict;
  end
endmodule // prioritized_interrupt_controller_bench
`default_nettype wire
